// ---- dual_timer_counter_core.sv ----
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dual_timer_counter_core #(
  parameter int unsigned TICK_DIV = timer_pkg::TICK_DIV_DEF,
  parameter int unsigned TICK_W   = 8
) (
  // Clock, reset and freeze.
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // External pins.
  input  wire logic        countPin0,
  input  wire logic        countPin1,
  input  wire logic        gateInputPin0,
  input  wire logic        gateInputPin1,
  // Overflow requests and baud tick.
  output logic             unit0OverflowFlag,
  output logic             unit1OverflowFlag,
  output logic             baudTick
);

  // Pin synchronisers: bit 0 count pin 0, bit 1 count pin 1, bit 2 gate 0, bit 3 gate 1.
  logic [3:0] pinMetaReg;
  logic [3:0] pinSyncReg;
  logic [3:0] pinPrevReg;
  logic [3:0] pinFall;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pinMetaReg <= 4'hF;
      pinSyncReg <= 4'hF;
      pinPrevReg <= 4'hF;
    end else if (ce) begin
      pinMetaReg <= {gateInputPin1, gateInputPin0, countPin1, countPin0};
      pinSyncReg <= pinMetaReg;
      pinPrevReg <= pinSyncReg;
    end
  end

  assign pinFall = pinPrevReg & ~pinSyncReg;

  // Time reference divider.
  localparam logic [TICK_W-1:0] DIV_LAST  = TICK_W'(TICK_DIV - 1);
  localparam logic [TICK_W-1:0] HALF_LAST = TICK_W'((TICK_DIV + 1) / 2 - 1);

  logic [TICK_W-1:0] divReg;
  logic [TICK_W-1:0] divNext;
  logic              tickReg;
  logic              tickNext;
  logic [7:0]        configReg;
  logic [TICK_W-1:0] divLast;

  assign divLast = configReg[timer_pkg::CFG_DOUBLE_SPEED] ? HALF_LAST : DIV_LAST;

  always_comb begin
    tickNext = 1'b0;
    divNext  = divReg + TICK_W'(1);
    if (divReg >= divLast) begin
      divNext  = '0;
      tickNext = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      divReg  <= '0;
      tickReg <= 1'b0;
    end else if (ce) begin
      divReg  <= divNext;
      tickReg <= tickNext;
    end
  end

  // Bus handshake. These flops keep running while ce is low so that an accepted
  // address phase is never lost; the access itself waits for ce.
  logic       pendReg;
  logic       pendNext;
  logic       pendWriteReg;
  logic       pendWriteNext;
  logic [7:0] pendIdxReg;
  logic [7:0] pendIdxNext;
  logic       readyReg;
  logic       readyNext;
  logic       accept;
  logic       doAccess;
  logic       doWrite;

  assign accept   = hsel & htrans[1] & hready;
  assign doAccess = pendReg & ce;
  assign doWrite  = doAccess & pendWriteReg;

  always_comb begin
    pendNext      = pendReg;
    pendWriteNext = pendWriteReg;
    pendIdxNext   = pendIdxReg;
    readyNext     = ce;
    if (doAccess) begin
      pendNext = 1'b0;
    end else if (pendReg) begin
      readyNext = 1'b0;
    end
    if (accept) begin
      pendNext      = 1'b1;
      pendWriteNext = hwrite & (hsize == timer_pkg::HSIZE_WORD);
      pendIdxNext   = haddr[9:2];
      readyNext     = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pendReg      <= 1'b0;
      pendWriteReg <= 1'b0;
      pendIdxReg   <= 8'h00;
      readyReg     <= 1'b1;
    end else begin
      pendReg      <= pendNext;
      pendWriteReg <= pendWriteNext;
      pendIdxReg   <= pendIdxNext;
      readyReg     <= readyNext;
    end
  end

  // Control, mode and configuration registers.
  logic [7:0] modeReg;
  logic [7:0] modeNext;
  logic [7:0] ctrlReg;
  logic [7:0] ctrlNext;
  logic [7:0] configNext;
  logic [7:0] wByte;
  logic       wrCtrl;
  logic [7:0] u0Low;
  logic [7:0] u0High;
  logic [7:0] u1Low;
  logic [7:0] u1High;
  logic       u0Ovf;
  logic       u0HighOvf;
  logic       u1Ovf;
  logic       unit0Split;
  logic       x0Set;
  logic       x1Set;

  assign wByte      = hwdata[7:0];
  assign wrCtrl     = doWrite & (pendIdxReg == timer_pkg::IDX_CONTROL);
  assign unit0Split = (modeReg[timer_pkg::MODE_U0_HI:timer_pkg::MODE_U0_LO] == 2'b11);
  // A low level or a falling edge, by the type bit, requests an external interrupt.
  assign x0Set = ctrlReg[timer_pkg::CTRL_X0_TYPE] ? pinFall[2] : ~pinSyncReg[2];
  assign x1Set = ctrlReg[timer_pkg::CTRL_X1_TYPE] ? pinFall[3] : ~pinSyncReg[3];

  always_comb begin
    modeNext   = modeReg;
    configNext = configReg;
    ctrlNext   = wrCtrl ? wByte : ctrlReg;
    if (doWrite && pendIdxReg == timer_pkg::IDX_MODE) begin
      modeNext = wByte;
    end
    if (doWrite && pendIdxReg == timer_pkg::IDX_CONFIG) begin
      configNext = {7'h00, wByte[timer_pkg::CFG_DOUBLE_SPEED]};
    end
    // Hardware sets win over a software clear in the same cycle.
    if (u0Ovf) begin
      ctrlNext[timer_pkg::CTRL_U0_OVF] = 1'b1;
    end
    if (unit0Split ? u0HighOvf : u1Ovf) begin
      ctrlNext[timer_pkg::CTRL_U1_OVF] = 1'b1;
    end
    if (x0Set) begin
      ctrlNext[timer_pkg::CTRL_X0_FLAG] = 1'b1;
    end
    if (x1Set) begin
      ctrlNext[timer_pkg::CTRL_X1_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      modeReg   <= timer_pkg::MODE_RESET;
      ctrlReg   <= timer_pkg::CONTROL_RESET;
      configReg <= timer_pkg::CONFIG_RESET;
    end else if (ce) begin
      modeReg   <= modeNext;
      ctrlReg   <= ctrlNext;
      configReg <= configNext;
    end
  end

  // The two counting units. With unit 0 split, unit 1 runs free and is stopped
  // only by its own halt mode or by its gate input.
  logic u1Run;
  assign u1Run = unit0Split | ctrlReg[timer_pkg::CTRL_U1_RUN];

  timer_unit #(
    .HOLD_IN_MODE3 (1'b0)
  ) u_unit0 (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .ce           (ce),
    .countTick    (tickReg),
    .pinEdge      (pinFall[0]),
    .gateLevel    (pinSyncReg[2]),
    .run          (ctrlReg[timer_pkg::CTRL_U0_RUN]),
    .gateCtrl     (modeReg[timer_pkg::MODE_U0_GATE]),
    .srcSel       (modeReg[timer_pkg::MODE_U0_SRC]),
    .mode         (modeReg[timer_pkg::MODE_U0_HI:timer_pkg::MODE_U0_LO]),
    .highRun      (ctrlReg[timer_pkg::CTRL_U1_RUN]),
    .wrLow        (doWrite && pendIdxReg == timer_pkg::IDX_U0_LOW),
    .wrHigh       (doWrite && pendIdxReg == timer_pkg::IDX_U0_HIGH),
    .wrData       (wByte),
    .countLow     (u0Low),
    .countHigh    (u0High),
    .overflow     (u0Ovf),
    .highOverflow (u0HighOvf)
  );

  timer_unit #(
    .HOLD_IN_MODE3 (1'b1)
  ) u_unit1 (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .ce           (ce),
    .countTick    (tickReg),
    .pinEdge      (pinFall[1]),
    .gateLevel    (pinSyncReg[3]),
    .run          (u1Run),
    .gateCtrl     (modeReg[timer_pkg::MODE_U1_GATE]),
    .srcSel       (modeReg[timer_pkg::MODE_U1_SRC]),
    .mode         (modeReg[timer_pkg::MODE_U1_HI:timer_pkg::MODE_U1_LO]),
    .highRun      (1'b0),
    .wrLow        (doWrite && pendIdxReg == timer_pkg::IDX_U1_LOW),
    .wrHigh       (doWrite && pendIdxReg == timer_pkg::IDX_U1_HIGH),
    .wrData       (wByte),
    .countLow     (u1Low),
    .countHigh    (u1High),
    .overflow     (u1Ovf),
    .highOverflow ()
  );

  // Read data and output registers.
  logic [7:0]  readByte;
  logic [31:0] rdataReg;
  logic [31:0] rdataNext;
  logic        baudReg;
  logic        hrespReg;

  always_comb begin
    unique case (pendIdxReg)
      timer_pkg::IDX_CONTROL: readByte = ctrlReg;
      timer_pkg::IDX_MODE:    readByte = modeReg;
      timer_pkg::IDX_U0_LOW:  readByte = u0Low;
      timer_pkg::IDX_U1_LOW:  readByte = u1Low;
      timer_pkg::IDX_U0_HIGH: readByte = u0High;
      timer_pkg::IDX_U1_HIGH: readByte = u1High;
      timer_pkg::IDX_CONFIG:  readByte = configReg;
      default:                readByte = 8'h00;
    endcase
    rdataNext = rdataReg;
    if (doAccess && !pendWriteReg) begin
      rdataNext = {24'h000000, readByte};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdataReg <= 32'h00000000;
      baudReg  <= 1'b0;
      hrespReg <= timer_pkg::HRESP_OKAY;
    end else if (ce) begin
      rdataReg <= rdataNext;
      baudReg  <= u1Ovf;
      hrespReg <= timer_pkg::HRESP_OKAY;
    end
  end

  assign hreadyout         = readyReg;
  assign hresp             = hrespReg;
  assign hrdata            = rdataReg;
  assign unit0OverflowFlag = ctrlReg[timer_pkg::CTRL_U0_OVF];
  assign unit1OverflowFlag = ctrlReg[timer_pkg::CTRL_U1_OVF];
  assign baudTick          = baudReg;

  property p_mode_reset;
    @(posedge ref_clk) $fell(srst) |-> (modeReg == 8'h00) && (ctrlReg == 8'h00);
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("Mode register was not zero after reset.");

  property p_u1_flag;
    @(posedge ref_clk) disable iff (srst)
    (ce && u1Ovf && !unit0Split) |=> unit1OverflowFlag;
  endproperty
  a_u1_flag: assert property (p_u1_flag)
    else $error("Unit 1 overflow did not set its flag.");

  property p_split_flag;
    @(posedge ref_clk) disable iff (srst)
    (ce && unit0Split && u0HighOvf) |=> unit1OverflowFlag;
  endproperty
  a_split_flag: assert property (p_split_flag)
    else $error("Split unit 0 high byte overflow did not set the unit 1 flag.");

  property p_baud;
    @(posedge ref_clk) disable iff (srst)
    (ce && u1Ovf) |=> baudTick ##1 (!ce || !baudTick || $past(u1Ovf));
  endproperty
  a_baud: assert property (p_baud)
    else $error("Baud tick did not follow the unit 1 overflow.");

  property p_tick_fast;
    @(posedge ref_clk) disable iff (srst)
    (ce && configReg[timer_pkg::CFG_DOUBLE_SPEED] && divReg >= HALF_LAST)
      |=> tickReg && (divReg == '0);
  endproperty
  a_tick_fast: assert property (p_tick_fast)
    else $error("Double-speed mode did not halve the divider.");

  c_reload: cover property (@(posedge ref_clk) disable iff (srst)
    modeReg[5:4] == 2'b10 && u1Ovf);
  c_split: cover property (@(posedge ref_clk) disable iff (srst)
    unit0Split && u0HighOvf);
  c_read: cover property (@(posedge ref_clk) disable iff (srst)
    doAccess && !pendWriteReg && pendIdxReg == timer_pkg::IDX_U0_LOW);

endmodule

// ---- timer_pkg.sv ----
package timer_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [7:0] IDX_CONTROL  = 8'h88;
  localparam logic [7:0] IDX_MODE     = 8'h89;
  localparam logic [7:0] IDX_U0_LOW   = 8'h8A;
  localparam logic [7:0] IDX_U1_LOW   = 8'h8B;
  localparam logic [7:0] IDX_U0_HIGH  = 8'h8C;
  localparam logic [7:0] IDX_U1_HIGH  = 8'h8D;
  localparam logic [7:0] IDX_CONFIG   = 8'h8E;

  // Control register bit positions.
  localparam int CTRL_U1_OVF   = 7;
  localparam int CTRL_U1_RUN   = 6;
  localparam int CTRL_U0_OVF   = 5;
  localparam int CTRL_U0_RUN   = 4;
  localparam int CTRL_X1_FLAG  = 3;
  localparam int CTRL_X1_TYPE  = 2;
  localparam int CTRL_X0_FLAG  = 1;
  localparam int CTRL_X0_TYPE  = 0;

  // Mode register bit positions.
  localparam int MODE_U1_GATE  = 7;
  localparam int MODE_U1_SRC   = 6;
  localparam int MODE_U1_HI    = 5;
  localparam int MODE_U1_LO    = 4;
  localparam int MODE_U0_GATE  = 3;
  localparam int MODE_U0_SRC   = 2;
  localparam int MODE_U0_HI    = 1;
  localparam int MODE_U0_LO    = 0;

  // Configuration register bit positions.
  localparam int CFG_DOUBLE_SPEED = 0;

  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] CONFIG_RESET  = 8'h00;

  // Counting constants.
  localparam logic [4:0] PRESCALE_TOP  = 5'h1F;
  localparam logic [7:0] BYTE_TOP      = 8'hFF;
  localparam int         TICK_DIV_DEF  = 12;

  // Bus constants.
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } timer_mode_t;

endpackage

// ---- timer_unit.sv ----
`timescale 1ns/1ps
module timer_unit #(
  parameter bit HOLD_IN_MODE3 = 1'b0
) (
  // Clock, reset and freeze.
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  // Count sources and control.
  input  wire logic       countTick,
  input  wire logic       pinEdge,
  input  wire logic       gateLevel,
  input  wire logic       run,
  input  wire logic       gateCtrl,
  input  wire logic       srcSel,
  input  wire logic [1:0] mode,
  input  wire logic       highRun,
  // Software writes.
  input  wire logic       wrLow,
  input  wire logic       wrHigh,
  input  wire logic [7:0] wrData,
  // Count state and overflow pulses.
  output logic      [7:0] countLow,
  output logic      [7:0] countHigh,
  output logic            overflow,
  output logic            highOverflow
);

  logic [7:0]  lowReg;
  logic [7:0]  lowNext;
  logic [7:0]  highReg;
  logic [7:0]  highNext;
  logic        ovfReg;
  logic        ovfNext;
  logic        hovfReg;
  logic        hovfNext;
  logic        enable;
  logic        step;
  logic [15:0] wide;
  timer_pkg::timer_mode_t modeSel;

  assign modeSel = timer_pkg::timer_mode_t'(mode);
  assign enable  = run & (~gateCtrl | gateLevel);
  assign step    = enable & (srcSel ? pinEdge : countTick);
  assign wide    = {highReg, lowReg} + 16'h0001;

  always_comb begin
    lowNext  = lowReg;
    highNext = highReg;
    ovfNext  = 1'b0;
    hovfNext = 1'b0;
    unique case (modeSel)
      timer_pkg::MODE_13BIT: begin
        if (step) begin
          if (lowReg[4:0] == timer_pkg::PRESCALE_TOP) begin
            lowNext  = {lowReg[7:5], 5'h00};
            highNext = highReg + 8'h01;
            ovfNext  = (highReg == timer_pkg::BYTE_TOP);
          end else begin
            lowNext = {lowReg[7:5], lowReg[4:0] + 5'h01};
          end
        end
      end
      timer_pkg::MODE_16BIT: begin
        if (step) begin
          {highNext, lowNext} = wide;
          ovfNext = &{highReg, lowReg};
        end
      end
      timer_pkg::MODE_RELOAD: begin
        if (step) begin
          if (lowReg == timer_pkg::BYTE_TOP) begin
            lowNext = highReg;
            ovfNext = 1'b1;
          end else begin
            lowNext = lowReg + 8'h01;
          end
        end
      end
      timer_pkg::MODE_SPLIT: begin
        // Unit 1 holds here; unit 0 splits into two 8-bit timers.
        if (!HOLD_IN_MODE3) begin
          if (step) begin
            lowNext = lowReg + 8'h01;
            ovfNext = (lowReg == timer_pkg::BYTE_TOP);
          end
          if (highRun && countTick) begin
            highNext = highReg + 8'h01;
            hovfNext = (highReg == timer_pkg::BYTE_TOP);
          end
        end
      end
    endcase
    if (wrLow) begin
      lowNext = wrData;
    end
    if (wrHigh) begin
      highNext = wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lowReg  <= timer_pkg::COUNT_RESET;
      highReg <= timer_pkg::COUNT_RESET;
      ovfReg  <= 1'b0;
      hovfReg <= 1'b0;
    end else if (ce) begin
      lowReg  <= lowNext;
      highReg <= highNext;
      ovfReg  <= ovfNext;
      hovfReg <= hovfNext;
    end
  end

  assign countLow     = lowReg;
  assign countHigh    = highReg;
  assign overflow     = ovfReg;
  assign highOverflow = hovfReg;

  logic quiet;
  assign quiet = ce & ~wrLow & ~wrHigh;

  property p_prescale_carry;
    @(posedge ref_clk) disable iff (srst)
    (quiet && step && mode == 2'b00 && lowReg[4:0] == 5'h1F)
      |=> (highReg == $past(highReg) + 8'h01) && (lowReg[4:0] == 5'h00)
          && (lowReg[7:5] == $past(lowReg[7:5]));
  endproperty
  a_prescale_carry: assert property (p_prescale_carry)
    else $error("Prescaler overflow did not advance the high byte.");

  property p_cascade_wrap;
    @(posedge ref_clk) disable iff (srst)
    (quiet && step && mode == 2'b01 && {highReg, lowReg} == 16'hFFFF)
      |=> ({highReg, lowReg} == 16'h0000) && overflow;
  endproperty
  a_cascade_wrap: assert property (p_cascade_wrap)
    else $error("16-bit wrap did not clear the count and pulse overflow.");

  property p_reload;
    @(posedge ref_clk) disable iff (srst)
    (quiet && step && mode == 2'b10 && lowReg == 8'hFF)
      |=> (lowReg == $past(highReg)) && $stable(highReg) && overflow;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Auto-reload did not copy the high byte into the low byte.");

  property p_hold;
    @(posedge ref_clk) disable iff (srst)
    (HOLD_IN_MODE3 && quiet && mode == 2'b11) |=> $stable(lowReg) && $stable(highReg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Unit changed its count while halted.");

  property p_gated_off;
    @(posedge ref_clk) disable iff (srst)
    (quiet && gateCtrl && !gateLevel && mode != 2'b11) |=> $stable(lowReg) && !overflow;
  endproperty
  a_gated_off: assert property (p_gated_off)
    else $error("Unit counted while its gate input was low.");

  property p_source_pin;
    @(posedge ref_clk) disable iff (srst)
    (quiet && enable && srcSel && !pinEdge && mode != 2'b11) |=> $stable(lowReg);
  endproperty
  a_source_pin: assert property (p_source_pin)
    else $error("Counter mode advanced without a pin falling edge.");

endmodule

// ---- pin_model.sv ----
`timescale 1ns/1ps
module pin_model (
  // Clock.
  input  wire logic ref_clk,
  // Pins toward the block.
  output logic      countPin0,
  output logic      countPin1,
  output logic      gateInputPin0,
  output logic      gateInputPin1
);
  initial begin
    countPin0 = 1'b1;
    countPin1 = 1'b1;
    gateInputPin0 = 1'b1;
    gateInputPin1 = 1'b1;
  end

  // Each level is held three cycles so the sampler sees every edge.
  task automatic pulse(input int unit, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (3) @(posedge ref_clk);
      if (unit == 0) countPin0 <= 1'b0;
      else countPin1 <= 1'b0;
      repeat (3) @(posedge ref_clk);
      if (unit == 0) countPin0 <= 1'b1;
      else countPin1 <= 1'b1;
    end
  endtask

  task automatic gate(input int unit, input logic lvl);
    @(posedge ref_clk);
    if (unit == 0) gateInputPin0 <= lvl;
    else gateInputPin1 <= lvl;
  endtask
endmodule

// ---- dual_timer_counter_core_test.sv ----
`timescale 1ns/1ps
module dual_timer_counter_core_test;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, u0Flag, u1Flag, baudTick, cp0, cp1, gp0, gp1;
  logic [7:0]  expQ[$];
  logic [16:0] lfsrState = 17'h17D31;
  logic [7:0]  r;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  event        rdEv;

  always #25 ref_clk = ~ref_clk;

  dual_timer_counter_core #(.TICK_DIV(2), .TICK_W(8)) u_dual_timer_counter_core (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .countPin0(cp0), .countPin1(cp1), .gateInputPin0(gp0), .gateInputPin1(gp1),
    .unit0OverflowFlag(u0Flag), .unit1OverflowFlag(u1Flag), .baudTick(baudTick));

  pin_model u_pin_model (.ref_clk(ref_clk), .countPin0(cp0), .countPin1(cp1),
    .gateInputPin0(gp0), .gateInputPin1(gp1));

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One single word transfer; the address phase is held until hready is seen high.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    expQ.push_back(exp);
    bus(1'b0, idx, 8'h00);
    ->rdEv;
  endtask

  always @(rdEv) check(hrdata[7:0], expQ.pop_front());

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  // Counts pin edges on one unit, then stops it and reads both count bytes.
  task automatic pinCase(input int unit, input logic [7:0] mode, input logic [7:0] lo,
      input logic [7:0] hi, input int n, input logic [7:0] ctl, input logic [7:0] eLo,
      input logic [7:0] eHi);
    logic [7:0] b;
    b = (unit == 1) ? 8'h01 : 8'h00;
    bus(1'b1, timer_pkg::IDX_MODE, mode);
    bus(1'b1, timer_pkg::IDX_U0_LOW + b, lo);
    bus(1'b1, timer_pkg::IDX_U0_HIGH + b, hi);
    bus(1'b1, timer_pkg::IDX_CONTROL, (unit == 1) ? 8'h40 : 8'h10);
    u_pin_model.pulse(unit, n);
    repeat (8) @(posedge ref_clk);
    rd(timer_pkg::IDX_CONTROL, ctl);
    bus(1'b1, timer_pkg::IDX_CONTROL, 8'h00);
    rd(timer_pkg::IDX_U0_LOW + b, eLo);
    rd(timer_pkg::IDX_U0_HIGH + b, eHi);
    $display("pin case unit %0d mode %h done", unit, mode);
  endtask

  // Runs unit 0 as a 16-bit timer over 14 edges, four of them frozen by ce, then reads it.
  task automatic speedCase(input logic [7:0] cfg, input logic [7:0] eLo);
    bus(1'b1, timer_pkg::IDX_CONFIG, cfg);
    bus(1'b1, timer_pkg::IDX_MODE, 8'h01);
    bus(1'b1, timer_pkg::IDX_U0_LOW, 8'h00);
    bus(1'b1, timer_pkg::IDX_CONTROL, 8'h10);
    repeat (3) @(posedge ref_clk);
    ce <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ce <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b1, timer_pkg::IDX_CONTROL, 8'h00);
    rd(timer_pkg::IDX_U0_LOW, eLo);
    $display("speed case config %h done", cfg);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    rd(timer_pkg::IDX_MODE, 8'h00);
    rd(timer_pkg::IDX_CONTROL, 8'h00);
    rd(8'h40, 8'h00);
    check({7'h0, hresp}, 8'h00);
    lfsrState = lfsr(lfsrState);
    r = lfsrState[7:0] & 8'hCC;
    bus(1'b1, timer_pkg::IDX_MODE, r);
    rd(timer_pkg::IDX_MODE, r);
    $display("reset and access test done");
    lfsrState = lfsr(lfsrState);
    r = lfsrState[7:0];
    pinCase(0, 8'h06, 8'hFF, r, 1, 8'h30, r, r);
    pinCase(0, 8'h05, 8'hFF, 8'h12, 1, 8'h10, 8'h00, 8'h13);
    u_pin_model.gate(0, 1'b0);
    pinCase(0, 8'h0D, 8'h05, 8'h00, 2, 8'h12, 8'h05, 8'h00);
    u_pin_model.gate(0, 1'b1);
    pinCase(0, 8'h0D, 8'h05, 8'h00, 2, 8'h10, 8'h07, 8'h00);
    pinCase(1, 8'h40, 8'hFF, 8'h00, 1, 8'h40, 8'hE0, 8'h01);
    pinCase(1, 8'h70, 8'h10, 8'h00, 2, 8'h40, 8'h10, 8'h00);
    u_pin_model.gate(1, 1'b0);
    pinCase(1, 8'hC0, 8'h10, 8'h00, 1, 8'h48, 8'h10, 8'h00);
    u_pin_model.gate(1, 1'b1);
    bus(1'b1, timer_pkg::IDX_U1_HIGH, 8'hF0);
    bus(1'b1, timer_pkg::IDX_U1_LOW, 8'hFE);
    bus(1'b1, timer_pkg::IDX_MODE, 8'h20);
    bus(1'b1, timer_pkg::IDX_CONTROL, 8'h40);
    for (int i = 0; i < 100 && u1Flag !== 1'b1; i++) @(posedge ref_clk);
    check({7'h0, u1Flag}, 8'h01);
    check({7'h0, baudTick}, 8'h01);
    bus(1'b1, timer_pkg::IDX_CONTROL, 8'h80);
    rd(timer_pkg::IDX_U1_HIGH, 8'hF0);
    rd(timer_pkg::IDX_CONTROL, 8'h80);
    $display("auto reload test done");
    bus(1'b1, timer_pkg::IDX_U0_HIGH, 8'hFE);
    bus(1'b1, timer_pkg::IDX_MODE, 8'h33);
    bus(1'b1, timer_pkg::IDX_CONTROL, 8'h40);
    for (int i = 0; i < 100 && u1Flag !== 1'b1; i++) @(posedge ref_clk);
    check({7'h0, u1Flag}, 8'h01);
    check({7'h0, u0Flag}, 8'h00);
    bus(1'b1, timer_pkg::IDX_CONTROL, 8'h05);
    u_pin_model.gate(0, 1'b0);
    repeat (3) @(posedge ref_clk);
    u_pin_model.gate(0, 1'b1);
    repeat (6) @(posedge ref_clk);
    rd(timer_pkg::IDX_CONTROL, 8'h07);
    $display("split and edge request test done");
    speedCase(8'h01, 8'h0A);
    speedCase(8'h00, 8'h05);
    repeat (4) @(posedge ref_clk);
    finish_test();
  end
endmodule
